// ---- common/ast_pkg.sv ----
// Purpose: Shared constants and types for the asynchronous serial transceiver.
// Assumes: 16-bit register port, 3-bit register address, 100 MHz clock.
// Notes:   The divisor reset value is arbitrary and gives a fast rate for simulation.
`default_nettype none
package ast_pkg;
  // Register addresses.
  localparam logic [2:0] ADDR_TXCTL  = 3'h0;
  localparam logic [2:0] ADDR_RXCTL  = 3'h1;
  localparam logic [2:0] ADDR_TXBUF  = 3'h2;
  localparam logic [2:0] ADDR_RXBUF  = 3'h3;
  localparam logic [2:0] ADDR_DIV    = 3'h4;
  localparam logic [2:0] ADDR_BAUD   = 3'h5;
  localparam logic [2:0] ADDR_INTEN  = 3'h6;
  // Transmit control/status bit positions.
  localparam int TX_EN_B    = 0;
  localparam int TX_NINE_B  = 1;
  localparam int TX_BIT9_B  = 2;
  localparam int TX_SYNC_B  = 3;
  localparam int TX_EMPTY_B = 4;
  localparam int TX_FLAG_B  = 5;
  // Receive control/status bit positions.
  localparam int RX_SERIAL_PORT_ENABLE_B  = 0;
  localparam int RX_EN_B    = 1;
  localparam int RX_NINE_B  = 2;
  localparam int RX_ADDR_B  = 3;
  localparam int RX_FRAMING_ERROR_STATUS_B  = 4;
  localparam int RX_OVERRUN_ERROR_FLAG_B  = 5;
  localparam int RX_BIT9_B  = 6;
  localparam int RX_FLAG_B  = 7;
  // Baud control and interrupt enable bit positions.
  localparam int BAUD_POL_B = 0;
  localparam int IE_RX_B    = 0;
  localparam int IE_TX_B    = 1;
  localparam int IE_PERI_B  = 2;
  localparam int IE_GLOB_B  = 3;
  // Reset values and counts.
  localparam logic [15:0] DIV_RESET   = 16'h0003;
  localparam logic [15:0] REG_ZERO    = 16'h0000;
  localparam logic [3:0]  SUB_LAST    = 4'hf;
  localparam logic [3:0]  SUB_HALF    = 4'h7;
  localparam logic [3:0]  SUB_SMP0    = 4'hd;
  localparam logic [3:0]  SUB_SMP1    = 4'he;
  localparam logic [3:0]  TX_BITS_8   = 4'ha;
  localparam logic [3:0]  TX_BITS_9   = 4'hb;
  localparam logic [3:0]  RX_LAST_8   = 4'h7;
  localparam logic [3:0]  RX_LAST_9   = 4'h8;
  localparam logic [1:0]  FIFO_DEPTH  = 2'h2;

  // One receive FIFO entry.
  typedef struct packed {
    logic       framing_error_status;
    logic       bit9;
    logic [7:0] data;
  } ast_rx_entry_t;

  typedef enum logic [2:0] {TX_IDLE = 3'b001, TX_SHIFT = 3'b010, TX_GAP = 3'b100} ast_tx_state_t;
  typedef enum logic [3:0] {RX_IDLE = 4'b0001, RX_START = 4'b0010, RX_DATA = 4'b0100,
                            RX_STOP = 4'b1000} ast_rx_state_t;

  // Two-of-three vote on a bit centre.
  function automatic logic ast_majority(input logic a, input logic b, input logic c);
    return (a & b) | (a & c) | (b & c);
  endfunction
endpackage
`default_nettype wire

// ---- logic/ast_transceiver.sv ----
// Purpose: Asynchronous serial transmitter and receiver behind a simple register port.
// Assumes: rx_in is synchronous to clk; one divisor tick is one sixteenth of a bit.
// Notes:   Read data appear one cycle after the read strobe; a receive buffer read pops.
// Behaviour
// - Setting transmitter enable raises the transmit-buffer-empty flag at once.
// - Writing a character to the transmit buffer starts its transmission.
// - Polarity bit set inverts transmitted idle and data levels.
// - Receive line sampled sixteen times per bit; shift register moves per bit.
// - Receiver runs only with receiver enable, port enable, synchronous mode off.
// - Falling edge starts; a high line at half bit aborts silently.
// - Each following bit centre a full bit later, majority voted, shifted.
// - Stop bit sampled one bit later; low sets framing error, high clears.
// - Finished character moves into a two-entry FIFO, raising receive flag.
// - Reading the receive buffer returns and removes the oldest character.
// - Receive flag read-only, set when enabled and FIFO holds a character.
// - Receive interrupt needs receive, peripheral and global enables all set.
// - Framing bit stored per entry; status shows only the oldest one.
// - Framing status read-only; port disable clears it, receiver disable not.
// - Framing error neither interrupts nor stops further reception.
// - Third character with full FIFO sets overrun; nothing more is accepted.
// - Overrun clears only by clearing receiver enable or port enable.
// - Nine-bit reception keeps a ninth bit status for the oldest character.
// - Address detection in nine-bit mode keeps only ninth-bit-set characters.
// - Frame: low start, eight or nine data bits LSB first, high stop.
// - Queued character loads one cycle after the previous stop bit ends.
// - Buffer-empty flag clear while a written character waits to load, or while transmitter enable is clear.
`timescale 1ns/1ps
`default_nettype none
module ast_transceiver (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [2:0]  addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [15:0] rdata,
  input  wire logic        rx_in,
  output logic             tx_out,
  output logic             rx_irq,
  output logic             tx_irq
);
  logic [15:0] txctl_q, rxctl_q, div_q, baud_q, inten_q, rdata_q;
  logic [15:0] baud_cnt_q;
  logic        tick;
  logic [7:0]  txbuf_q;
  logic        txbuf9_q, txbuf_full_q, tx_q, rx_irq_q, tx_irq_q;
  logic [10:0] tx_sh_q;
  logic [3:0]  tx_bits_q, tx_sub_q;
  ast_pkg::ast_tx_state_t tx_st_q;
  ast_pkg::ast_rx_state_t rx_st_q;
  logic [3:0]  rx_sub_q, rx_bit_q;
  logic [8:0]  rx_sh_q;
  logic [1:0]  smp_q;
  logic        rx_prev_q;
  ast_pkg::ast_rx_entry_t fifo_q [2];
  ast_pkg::ast_rx_entry_t head, incoming;
  logic        wp_q, rp_q, overrun_error_flag_q;
  logic [1:0]  cnt_q;
  logic        serial_port_enable, receiver_enable, rx9, address_detect_enable, tx_on, rx_on, transmit_buffer_empty_flag, receive_data_flag, vote;
  logic        stop_done, accept, pop, push, wr_rxctl;

  // Decoded control levels.
  assign serial_port_enable     = rxctl_q[ast_pkg::RX_SERIAL_PORT_ENABLE_B];
  assign receiver_enable     = rxctl_q[ast_pkg::RX_EN_B];
  assign rx9      = rxctl_q[ast_pkg::RX_NINE_B];
  assign address_detect_enable    = rxctl_q[ast_pkg::RX_ADDR_B];
  assign tx_on    = txctl_q[ast_pkg::TX_EN_B] & serial_port_enable & ~txctl_q[ast_pkg::TX_SYNC_B];
  assign rx_on    = receiver_enable & serial_port_enable & ~txctl_q[ast_pkg::TX_SYNC_B];
  assign transmit_buffer_empty_flag     = txctl_q[ast_pkg::TX_EN_B] & ~txbuf_full_q;
  assign receive_data_flag     = rx_on & (cnt_q != 2'h0);
  assign wr_rxctl = wr && addr == ast_pkg::ADDR_RXCTL;

  // Control registers; status bits are not stored here so writes cannot touch them.
  always_ff @(posedge clk) begin
    if (rst) begin
      txctl_q <= ast_pkg::REG_ZERO;
      rxctl_q <= ast_pkg::REG_ZERO;
      div_q   <= ast_pkg::DIV_RESET;
      baud_q  <= ast_pkg::REG_ZERO;
      inten_q <= ast_pkg::REG_ZERO;
    end else if (wr) begin
      case (addr)
        ast_pkg::ADDR_TXCTL: txctl_q <= wdata & 16'h000f;
        ast_pkg::ADDR_RXCTL: rxctl_q <= wdata & 16'h000f;
        ast_pkg::ADDR_DIV:   div_q   <= wdata;
        ast_pkg::ADDR_BAUD:  baud_q  <= wdata & 16'h0001;
        ast_pkg::ADDR_INTEN: inten_q <= wdata & 16'h000f;
        default: ;
      endcase
    end
  end

  // Sixteen-times oversampling tick; restarts on a divisor write so a new rate applies at once.
  always_ff @(posedge clk) begin
    if (rst || !serial_port_enable || (wr && addr == ast_pkg::ADDR_DIV)) begin
      baud_cnt_q <= ast_pkg::REG_ZERO;
    end else if (baud_cnt_q >= div_q) begin
      baud_cnt_q <= ast_pkg::REG_ZERO;
    end else begin
      baud_cnt_q <= baud_cnt_q + 16'h0001;
    end
  end
  assign tick = serial_port_enable && (baud_cnt_q >= div_q);

  // Transmit holding buffer; the ninth bit is taken with the byte write.
  always_ff @(posedge clk) begin
    if (rst || !serial_port_enable) begin
      txbuf_q      <= 8'h00;
      txbuf9_q     <= 1'b0;
      txbuf_full_q <= 1'b0;
    end else if (wr && addr == ast_pkg::ADDR_TXBUF) begin
      txbuf_q      <= wdata[7:0];
      txbuf9_q     <= txctl_q[ast_pkg::TX_BIT9_B];
      txbuf_full_q <= 1'b1;
    end else if (tx_st_q == ast_pkg::TX_IDLE && tx_on) begin
      txbuf_full_q <= 1'b0;
    end
  end

  // Transmit shifter; a gap state gives the one cycle between stop bit and next load.
  always_ff @(posedge clk) begin
    if (rst || !serial_port_enable) begin
      tx_st_q   <= ast_pkg::TX_IDLE;
      tx_sh_q   <= 11'h7ff;
      tx_bits_q <= 4'h0;
      tx_sub_q  <= 4'h0;
    end else begin
      case (tx_st_q)
        ast_pkg::TX_IDLE: begin
          if (tx_on && txbuf_full_q) begin
            tx_sh_q   <= txctl_q[ast_pkg::TX_NINE_B] ? {1'b1, txbuf9_q, txbuf_q, 1'b0}
                                                     : {2'b11, txbuf_q, 1'b0};
            tx_bits_q <= txctl_q[ast_pkg::TX_NINE_B] ? ast_pkg::TX_BITS_9 : ast_pkg::TX_BITS_8;
            tx_sub_q  <= 4'h0;
            tx_st_q   <= ast_pkg::TX_SHIFT;
          end
        end
        ast_pkg::TX_SHIFT: begin
          if (tick) begin
            tx_sub_q <= tx_sub_q + 4'h1;
            if (tx_sub_q == ast_pkg::SUB_LAST) begin
              tx_sh_q   <= {1'b1, tx_sh_q[10:1]};
              tx_bits_q <= tx_bits_q - 4'h1;
              if (tx_bits_q == 4'h1) begin
                tx_st_q <= ast_pkg::TX_GAP;
              end
            end
          end
        end
        ast_pkg::TX_GAP: tx_st_q <= ast_pkg::TX_IDLE;
        default: tx_st_q <= ast_pkg::TX_IDLE;
      endcase
    end
  end

  // Line driver; idle is a mark, flipped when polarity inversion is selected.
  always_ff @(posedge clk) begin
    if (rst) begin
      tx_q <= 1'b1;
    end else if (tx_st_q == ast_pkg::TX_SHIFT && serial_port_enable) begin
      tx_q <= tx_sh_q[0] ^ baud_q[ast_pkg::BAUD_POL_B];
    end else begin
      tx_q <= ~baud_q[ast_pkg::BAUD_POL_B];
    end
  end

  // Receive line history for start edge detection.
  always_ff @(posedge clk) begin
    if (rst) begin
      rx_prev_q <= 1'b1;
    end else begin
      rx_prev_q <= rx_in;
    end
  end

  assign vote      = ast_pkg::ast_majority(smp_q[0], smp_q[1], rx_in);
  assign stop_done = rx_st_q == ast_pkg::RX_STOP && tick && rx_sub_q == ast_pkg::SUB_LAST;

  // Receive state machine; disabling the receiver drops a partial character.
  always_ff @(posedge clk) begin
    if (rst || !rx_on) begin
      rx_st_q  <= ast_pkg::RX_IDLE;
      rx_sub_q <= 4'h0;
      rx_bit_q <= 4'h0;
      rx_sh_q  <= 9'h000;
      smp_q    <= 2'b11;
    end else begin
      case (rx_st_q)
        ast_pkg::RX_IDLE: begin
          rx_sub_q <= 4'h0;
          if (rx_prev_q && !rx_in) begin
            rx_st_q <= ast_pkg::RX_START;
          end
        end
        ast_pkg::RX_START: begin
          if (tick) begin
            rx_sub_q <= rx_sub_q + 4'h1;
            if (rx_sub_q == ast_pkg::SUB_HALF) begin
              rx_sub_q <= 4'h0;
              rx_bit_q <= 4'h0;
              rx_st_q  <= rx_in ? ast_pkg::RX_IDLE : ast_pkg::RX_DATA;
            end
          end
        end
        ast_pkg::RX_DATA, ast_pkg::RX_STOP: begin
          if (tick) begin
            rx_sub_q <= rx_sub_q + 4'h1;
            if (rx_sub_q == ast_pkg::SUB_SMP0) smp_q[0] <= rx_in;
            if (rx_sub_q == ast_pkg::SUB_SMP1) smp_q[1] <= rx_in;
            if (rx_sub_q == ast_pkg::SUB_LAST) begin
              if (rx_st_q == ast_pkg::RX_STOP) begin
                rx_st_q <= ast_pkg::RX_IDLE;
              end else begin
                rx_sh_q  <= {vote, rx_sh_q[8:1]};
                rx_bit_q <= rx_bit_q + 4'h1;
                if (rx_bit_q == (rx9 ? ast_pkg::RX_LAST_9 : ast_pkg::RX_LAST_8)) begin
                  rx_st_q <= ast_pkg::RX_STOP;
                end
              end
            end
          end
        end
        default: rx_st_q <= ast_pkg::RX_IDLE;
      endcase
    end
  end

  // Completed character; eight-bit frames sit one place higher in the shifter.
  always_comb begin
    incoming.framing_error_status = ~vote;
    incoming.bit9 = rx9 & rx_sh_q[8];
    incoming.data = rx9 ? rx_sh_q[7:0] : rx_sh_q[8:1];
  end
  assign head   = fifo_q[rp_q];
  assign accept = stop_done && !(address_detect_enable && rx9 && !incoming.bit9) && !overrun_error_flag_q;
  assign pop    = rd && addr == ast_pkg::ADDR_RXBUF && cnt_q != 2'h0;
  assign push   = accept && (cnt_q != ast_pkg::FIFO_DEPTH || pop);

  // Two-entry FIFO with per-entry framing bit; overrun blocks further pushes.
  always_ff @(posedge clk) begin
    if (rst || !serial_port_enable) begin
      fifo_q[0] <= '0;
      fifo_q[1] <= '0;
      wp_q      <= 1'b0;
      rp_q      <= 1'b0;
      cnt_q     <= 2'h0;
      overrun_error_flag_q    <= 1'b0;
    end else begin
      if (push) begin
        fifo_q[wp_q] <= incoming;
        wp_q         <= ~wp_q;
      end
      if (pop) begin
        rp_q <= ~rp_q;
      end
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
      if (accept && cnt_q == ast_pkg::FIFO_DEPTH && !pop) begin
        overrun_error_flag_q <= 1'b1;
      end else if (!receiver_enable) begin
        overrun_error_flag_q <= 1'b0;
      end
    end
  end

  // Read port; status comes from live state, and unmapped addresses read zero.
  always_ff @(posedge clk) begin
    if (rst || !rd) begin
      rdata_q <= ast_pkg::REG_ZERO;
    end else begin
      case (addr)
        ast_pkg::ADDR_TXCTL: begin
          rdata_q <= txctl_q;
          rdata_q[ast_pkg::TX_EMPTY_B] <= tx_st_q == ast_pkg::TX_IDLE;
          rdata_q[ast_pkg::TX_FLAG_B]  <= transmit_buffer_empty_flag;
        end
        ast_pkg::ADDR_RXCTL: begin
          rdata_q <= rxctl_q;
          rdata_q[ast_pkg::RX_FRAMING_ERROR_STATUS_B] <= cnt_q != 2'h0 && head.framing_error_status;
          rdata_q[ast_pkg::RX_OVERRUN_ERROR_FLAG_B] <= overrun_error_flag_q;
          rdata_q[ast_pkg::RX_BIT9_B] <= cnt_q != 2'h0 && head.bit9;
          rdata_q[ast_pkg::RX_FLAG_B] <= receive_data_flag;
        end
        ast_pkg::ADDR_RXBUF: rdata_q <= (cnt_q != 2'h0) ? {8'h00, head.data} : ast_pkg::REG_ZERO;
        ast_pkg::ADDR_DIV:   rdata_q <= div_q;
        ast_pkg::ADDR_BAUD:  rdata_q <= baud_q;
        ast_pkg::ADDR_INTEN: rdata_q <= inten_q;
        default:             rdata_q <= ast_pkg::REG_ZERO;
      endcase
    end
  end

  // Interrupt requests; framing status plays no part in them.
  always_ff @(posedge clk) begin
    if (rst) begin
      rx_irq_q <= 1'b0;
      tx_irq_q <= 1'b0;
    end else begin
      rx_irq_q <= receive_data_flag && inten_q[ast_pkg::IE_RX_B] && inten_q[ast_pkg::IE_PERI_B]
                  && inten_q[ast_pkg::IE_GLOB_B];
      tx_irq_q <= transmit_buffer_empty_flag && inten_q[ast_pkg::IE_TX_B] && inten_q[ast_pkg::IE_PERI_B]
                  && inten_q[ast_pkg::IE_GLOB_B];
    end
  end

  assign rdata  = rdata_q;
  assign tx_out = tx_q;
  assign rx_irq = rx_irq_q;
  assign tx_irq = tx_irq_q;

  // Checks on the design's own behaviour.
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_tx_enable_flag;
    wr && addr == ast_pkg::ADDR_TXCTL && wdata[ast_pkg::TX_EN_B] && !txbuf_full_q |=> transmit_buffer_empty_flag;
  endproperty
  a_tx_enable_flag: assert property (p_tx_enable_flag) else $error("enable did not raise empty flag");

  property p_idle_level;
    !serial_port_enable |=> tx_out == !$past(baud_q[ast_pkg::BAUD_POL_B]);
  endproperty
  a_idle_level: assert property (p_idle_level) else $error("idle line level wrong");

  property p_start_abort;
    rx_st_q == ast_pkg::RX_START && rx_on && tick && rx_sub_q == ast_pkg::SUB_HALF && rx_in
      |=> rx_st_q == ast_pkg::RX_IDLE && overrun_error_flag_q == $past(overrun_error_flag_q);
  endproperty
  a_start_abort: assert property (p_start_abort) else $error("false start not abandoned");

  property p_push_count;
    push && !pop && serial_port_enable |=> cnt_q == $past(cnt_q) + 2'h1;
  endproperty
  a_push_count: assert property (p_push_count) else $error("character not stored");

  property p_overrun_set;
    accept && cnt_q == ast_pkg::FIFO_DEPTH && !pop && serial_port_enable |=> overrun_error_flag_q && cnt_q == ast_pkg::FIFO_DEPTH;
  endproperty
  a_overrun_set: assert property (p_overrun_set) else $error("overrun not flagged");

  property p_overrun_hold;
    overrun_error_flag_q && receiver_enable && serial_port_enable && !wr_rxctl |=> overrun_error_flag_q;
  endproperty
  a_overrun_hold: assert property (p_overrun_hold) else $error("overrun cleared early");

  property p_port_reset;
    !serial_port_enable |=> cnt_q == 2'h0 && rx_st_q == ast_pkg::RX_IDLE && tx_st_q == ast_pkg::TX_IDLE;
  endproperty
  a_port_reset: assert property (p_port_reset) else $error("port disable did not reset");

  property p_addr_filter;
    stop_done && address_detect_enable && rx9 && !incoming.bit9 |=> cnt_q == $past(cnt_q) - {1'b0, $past(pop)};
  endproperty
  a_addr_filter: assert property (p_addr_filter) else $error("data character passed address filter");

  property p_rx_irq;
    rx_irq |-> $past(inten_q[ast_pkg::IE_RX_B] && inten_q[ast_pkg::IE_PERI_B] && inten_q[ast_pkg::IE_GLOB_B]);
  endproperty
  a_rx_irq: assert property (p_rx_irq) else $error("receive interrupt without all enables");

  property p_read_pop;
    pop |=> rdata[7:0] == $past(head.data) ##0 cnt_q != $past(cnt_q) || $past(push);
  endproperty
  a_read_pop: assert property (p_read_pop) else $error("receive read wrong");

  c_tx_frame:  cover property (tx_st_q == ast_pkg::TX_SHIFT ##[1:400] tx_st_q == ast_pkg::TX_GAP);
  c_rx_char:   cover property (push);
  c_overrun:   cover property ($rose(overrun_error_flag_q));
  c_framing_error_status_char: cover property (push && incoming.framing_error_status);
endmodule // ast_transceiver
`default_nettype wire

// ---- testbench/ast_serial_node.sv ----
// Purpose: Remote serial node that sends frames to the receiver and captures the transmitter's frames.
// Assumes: One bit lasts BIT clocks; the line it drives idles high.
// Notes:   A start is taken only on an idle-to-active change, so set pol before the design switches polarity.
`timescale 1ns/1ps
`default_nettype none
module ast_serial_node #(
  parameter int BIT = 64
) (
  input  wire logic clk,
  input  wire logic line_in,
  output logic      line_out
);
  logic       pol = 1'b0;
  logic       nine = 1'b0;
  logic       prev = 1'b1;
  logic [8:0] v;
  logic [8:0] cap [0:7];
  int         cap_cnt = 0;

  initial line_out = 1'b1;

  // Frames one character LSB first; a low stop bit is sent on request to provoke a framing error.
  task automatic send(input logic [8:0] d, input int nb, input logic stop);
    line_out <= 1'b0;
    repeat (BIT) @(posedge clk);
    for (int i = 0; i < nb; i++) begin
      line_out <= d[i];
      repeat (BIT) @(posedge clk);
    end
    line_out <= stop;
    repeat (BIT) @(posedge clk);
    line_out <= 1'b1;
    repeat (BIT) @(posedge clk);
  endtask

  // A short low pulse that must not be taken for a start bit.
  task automatic pulse(input int n);
    line_out <= 1'b0;
    repeat (n) @(posedge clk);
    line_out <= 1'b1;
    repeat (2 * BIT) @(posedge clk);
  endtask

  // Samples each bit at its centre; polarity is removed so captures read as plain data.
  always begin : rx_side
    @(posedge clk);
    if (prev === ~pol && line_in === pol) begin
      v = 9'h000;
      repeat (BIT / 2) @(posedge clk);
      for (int i = 0; i < (nine ? 9 : 8); i++) begin
        repeat (BIT) @(posedge clk);
        v[i] = line_in ^ pol;
      end
      cap[cap_cnt[2:0]] = v;
      cap_cnt++;
    end
    prev = line_in;
  end
endmodule // ast_serial_node
`default_nettype wire

// ---- testbench/testbench.sv ----
// Purpose: Self-checking bench for the serial transceiver through its register port and serial pins.
// Assumes: Divisor left at its reset value, so one bit is sixty-four clocks.
// Notes:   Waits on the remote node are bounded; running out counts as a mismatch.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin err_total++; $display("BAD %s exp %h got %h", nm, e, g); end end
module testbench;
  localparam int         BIT = 16 * (ast_pkg::DIV_RESET + 1);
  localparam logic [2:0] TXC = ast_pkg::ADDR_TXCTL;
  localparam logic [2:0] RXC = ast_pkg::ADDR_RXCTL;
  localparam logic [2:0] RXB = ast_pkg::ADDR_RXBUF;
  localparam logic [2:0] TXB = ast_pkg::ADDR_TXBUF;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [2:0]  addr = 3'h0;
  logic [15:0] wdata = 16'h0000;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [15:0] rdata;
  logic        rx_in;
  logic        tx_out;
  logic        rx_irq;
  logic        tx_irq;
  int          err_total = 0;
  int          n_tests = 0;

  initial begin
    forever #5 clk = ~clk;
  end

  ast_transceiver u_ast_transceiver (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .rx_in(rx_in), .tx_out(tx_out), .rx_irq(rx_irq), .tx_irq(tx_irq));
  ast_serial_node #(.BIT(BIT)) u_ast_serial_node (.clk(clk), .line_in(tx_out), .line_out(rx_in));

  // Bus cycles: strobes last one cycle; read data are looked at in the cycle after the strobe.
  task automatic wr_reg(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [2:0] a, input logic [15:0] e, input string nm);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    `CHK(nm, e, rdata)
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Bounded wait for the remote node to capture n frames in all.
  task automatic wait_cap(input int n);
    int k;
    k = 0;
    while (u_ast_serial_node.cap_cnt < n && k < 4000) begin
      @(posedge clk);
      k++;
    end
    if (u_ast_serial_node.cap_cnt < n) begin
      err_total++;
      $display("BAD wait_cap exp %0d got %0d", n, u_ast_serial_node.cap_cnt);
      complete_run();
    end
  endtask

  // Main sequence: transmit first, then receive errors and modes, polarity last since it is not undone.
  initial begin : main
    cyc(2);
    rst <= 1'b0;
    rd_chk(TXC, 16'h0010, "txctl_rst");
    rd_chk(ast_pkg::ADDR_DIV, ast_pkg::DIV_RESET, "div_rst");
    rd_chk(3'h7, 16'h0000, "unmapped");
    `CHK("tx_idle", 1'b1, tx_out)
    wr_reg(RXC, 16'h0003);
    wr_reg(TXC, 16'h0001);
    rd_chk(TXC, 16'h0031, "tx_enable");
    wr_reg(TXB, 16'h00a5);
    wr_reg(TXB, 16'h003c);
    cyc(2);
    rd_chk(TXC, 16'h0001, "tx_queued");
    wait_cap(2);
    `CHK("tx_first", 9'h0a5, u_ast_serial_node.cap[0])
    `CHK("tx_second", 9'h03c, u_ast_serial_node.cap[1])
    cyc(BIT);
    u_ast_serial_node.nine = 1'b1;
    wr_reg(TXC, 16'h0007);
    wr_reg(TXB, 16'h0081);
    wait_cap(3);
    `CHK("tx_nine", 9'h181, u_ast_serial_node.cap[2])
    u_ast_serial_node.nine = 1'b0;
    cyc(2 * BIT);
    wr_reg(ast_pkg::ADDR_INTEN, 16'h000e);
    cyc(3);
    `CHK("tx_irq", 1'b1, tx_irq)
    // Three characters without a read: the second has a bad stop, the third overruns.
    u_ast_serial_node.send(9'h012, 8, 1'b1);
    u_ast_serial_node.send(9'h034, 8, 1'b0);
    u_ast_serial_node.send(9'h056, 8, 1'b1);
    wr_reg(ast_pkg::ADDR_INTEN, 16'h000d);
    cyc(3);
    `CHK("rx_irq_on", 1'b1, rx_irq)
    wr_reg(ast_pkg::ADDR_INTEN, 16'h0005);
    cyc(3);
    `CHK("rx_irq_off", 1'b0, rx_irq)
    rd_chk(RXC, 16'h00a3, "rx_overrun");
    rd_chk(RXB, 16'h0012, "rx_first");
    rd_chk(RXC, 16'h00b3, "rx_framing_error_status");
    rd_chk(RXB, 16'h0034, "rx_second");
    rd_chk(RXC, 16'h0023, "rx_drained");
    wr_reg(RXC, 16'h0001);
    rd_chk(RXC, 16'h0001, "overrun_error_flag_clear");
    u_ast_serial_node.send(9'h099, 8, 1'b1);
    wr_reg(RXC, 16'h0003);
    rd_chk(RXC, 16'h0003, "rx_disabled");
    u_ast_serial_node.pulse(BIT / 4);
    rd_chk(RXC, 16'h0003, "false_start");
    // Synchronous mode selected keeps the receiver idle.
    wr_reg(TXC, 16'h0009);
    u_ast_serial_node.send(9'h066, 8, 1'b1);
    rd_chk(RXC, 16'h0003, "rx_sync_off");
    wr_reg(TXC, 16'h0001);
    // Address detection keeps only characters whose ninth bit is set.
    wr_reg(RXC, 16'h000f);
    u_ast_serial_node.send(9'h0aa, 9, 1'b1);
    u_ast_serial_node.send(9'h1bb, 9, 1'b1);
    rd_chk(RXC, 16'h00cf, "rx_ninth");
    rd_chk(RXB, 16'h00bb, "rx_addr");
    // Once addressed, software drops detection so plain data characters come in.
    wr_reg(RXC, 16'h0007);
    u_ast_serial_node.send(9'h0cc, 9, 1'b1);
    rd_chk(RXC, 16'h0087, "rx_data_after_addr");
    rd_chk(RXB, 16'h00cc, "rx_data_char");
    // Framing status survives a receiver disable but not a port disable.
    wr_reg(RXC, 16'h0003);
    u_ast_serial_node.send(9'h044, 8, 1'b0);
    rd_chk(RXC, 16'h0093, "framing_error_status_set");
    wr_reg(RXC, 16'h0001);
    rd_chk(RXC, 16'h0011, "framing_error_status_kept");
    wr_reg(RXC, 16'h0000);
    wr_reg(RXC, 16'h0003);
    rd_chk(RXC, 16'h0003, "port_reset");
    // The node learns the new polarity first so the idle level change is not read as a start.
    u_ast_serial_node.pol = 1'b1;
    wr_reg(ast_pkg::ADDR_BAUD, 16'h0001);
    wr_reg(TXC, 16'h0001);
    cyc(3);
    `CHK("tx_inv_idle", 1'b0, tx_out)
    wr_reg(TXB, 16'h005a);
    wait_cap(4);
    `CHK("tx_inverted", 9'h05a, u_ast_serial_node.cap[3])
    complete_run();
  end
endmodule // testbench
`default_nettype wire
